// ==== inc/tlvip_regs.svh ====
`ifndef TLVIP_REGS_SVH
`define TLVIP_REGS_SVH

// Vector addresses, one per vector.
`define TLVIP_VEC1_ADDR 20'h0_0003
`define TLVIP_VEC2_ADDR 20'h0_000B
`define TLVIP_VEC3_ADDR 20'h0_0013
`define TLVIP_VEC4_ADDR 20'h0_001B
`define TLVIP_VEC5_ADDR 20'h0_0023
`define TLVIP_VEC6_ADDR 20'h0_002B
`define TLVIP_VEC7_ADDR 20'h0_0033
`define TLVIP_VEC8_ADDR 20'h0_003B
`define TLVIP_VEC9_ADDR 20'h0_0043
`define TLVIP_VEC10_ADDR 20'h0_004B

// Source bit positions in the flat source vector.
`define TLVIP_SRC_EXT0 0
`define TLVIP_SRC_EXT1 1
`define TLVIP_SRC_EXT2 2
`define TLVIP_SRC_TMR0_LO 3
`define TLVIP_SRC_EXT4 4
`define TLVIP_SRC_EXT3 5
`define TLVIP_SRC_BTICK 6
`define TLVIP_SRC_TMR0_HI 7
`define TLVIP_SRC_TMR1_LO 8
`define TLVIP_SRC_TMR1_HI 9
`define TLVIP_SRC_FPWM 10
`define TLVIP_SRC_SER1 11
`define TLVIP_SRC_ADC 12
`define TLVIP_SRC_PORT0 13
`define TLVIP_SRC_TPWM 14

// Reset value of the level stack depth.
`define TLVIP_DEPTH_RST 2'h0

`endif

// ==== inc/tlvip_pkg.sv ====
package tlvip_pkg;

  localparam int TLVIP_NSRC = 15;
  localparam int TLVIP_NVEC = 10;

  // Ordered so that a larger code is a higher level.
  typedef enum logic [1:0] {
    TLVIP_LVL_NONE,
    TLVIP_LVL_LOW,
    TLVIP_LVL_HIGH,
    TLVIP_LVL_HIGHEST
  } tlvip_lvl_e;

  typedef logic [19:0] tlvip_addr_t;
  typedef logic [TLVIP_NVEC-1:0] tlvip_vmask_t;

  typedef struct packed {
    logic valid;
    logic [3:0] vec_idx;
    tlvip_addr_t addr;
    tlvip_lvl_e lvl;
  } tlvip_grant_s;

endpackage

// ==== hw/tlvip_arbiter.sv ====
`timescale 1ns/10ps
`include "tlvip_regs.svh"
// Picks the highest-level pending vector, lowest index on a tie, and
// only if that level is strictly above the current service level.
module tlvip_arbiter
  import tlvip_pkg::*;
#(
  parameter int NVEC = 10
) (
  input wire logic [NVEC-1:0] pend_i,
  input wire logic [NVEC-1:0] sel_hi_i,
  input wire tlvip_lvl_e cur_lvl_i,
  output tlvip_grant_s grant_o
);

  tlvip_lvl_e vec_lvl [NVEC];
  tlvip_addr_t vec_addr [NVEC];

  assign vec_addr[0] = `TLVIP_VEC1_ADDR;
  assign vec_addr[1] = `TLVIP_VEC2_ADDR;
  assign vec_addr[2] = `TLVIP_VEC3_ADDR;
  assign vec_addr[3] = `TLVIP_VEC4_ADDR;
  assign vec_addr[4] = `TLVIP_VEC5_ADDR;
  assign vec_addr[5] = `TLVIP_VEC6_ADDR;
  assign vec_addr[6] = `TLVIP_VEC7_ADDR;
  assign vec_addr[7] = `TLVIP_VEC8_ADDR;
  assign vec_addr[8] = `TLVIP_VEC9_ADDR;
  assign vec_addr[9] = `TLVIP_VEC10_ADDR;

  // The first two vectors choose highest or low; the rest high or low.
  genvar gi;
  generate
    for (gi = 0; gi < NVEC; gi++) begin : g_lvl
      if (gi < 2) begin : g_x
        assign vec_lvl[gi] = sel_hi_i[gi] ? TLVIP_LVL_HIGHEST
                                          : TLVIP_LVL_LOW;
      end else begin : g_h
        assign vec_lvl[gi] = sel_hi_i[gi] ? TLVIP_LVL_HIGH
                                          : TLVIP_LVL_LOW;
      end
    end
  endgenerate

  // Scanning downward with >= lets the smaller index win a tie.
  always_comb begin
    grant_o = '0;
    grant_o.lvl = TLVIP_LVL_NONE;
    for (int i = NVEC - 1; i >= 0; i--) begin
      if (pend_i[i] && vec_lvl[i] > cur_lvl_i &&
          vec_lvl[i] >= grant_o.lvl) begin
        grant_o.valid = 1'b1;
        grant_o.vec_idx = 4'(i);
        grant_o.addr = vec_addr[i];
        grant_o.lvl = vec_lvl[i];
      end
    end
  end

endmodule // tlvip_arbiter

// ==== hw/tlvip_ctrl.sv ====
`timescale 1ns/10ps
`include "tlvip_regs.svh"
module tlvip_ctrl
  import tlvip_pkg::*;
#(
  parameter int NSRC = 15,
  parameter int NVEC = 10
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic [NSRC-1:0] SRC_REQ_I,
  input wire logic [NVEC-1:0] VEC_LVL_SEL_I,
  input wire logic CPU_ACK_I,
  input wire logic CPU_RETI_I,
  output logic IRQ_REQ_O,
  output logic [19:0] VEC_ADDR_O,
  output logic [3:0] VEC_IDX_O,
  output logic [1:0] CUR_LVL_O,
  output logic [NSRC-1:0] SRC_PEND_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Source pins come from other domains, so two flops precede any logic.

  logic [NSRC-1:0] sync1_ff;
  logic [NSRC-1:0] sync2_ff;

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= SRC_REQ_I;
      sync2_ff <= sync1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared vectors OR their sources; the handler reads SRC_PEND_O.

  logic [NVEC-1:0] vec_pend;

  always_comb begin
    vec_pend = '0;
    vec_pend[0] = sync2_ff[`TLVIP_SRC_EXT0];
    vec_pend[1] = sync2_ff[`TLVIP_SRC_EXT1];
    vec_pend[2] = sync2_ff[`TLVIP_SRC_EXT2] | sync2_ff[`TLVIP_SRC_TMR0_LO] |
                  sync2_ff[`TLVIP_SRC_EXT4];
    vec_pend[3] = sync2_ff[`TLVIP_SRC_EXT3] |
                  sync2_ff[`TLVIP_SRC_BTICK];
    vec_pend[4] = sync2_ff[`TLVIP_SRC_TMR0_HI];
    vec_pend[5] = sync2_ff[`TLVIP_SRC_TMR1_LO] | sync2_ff[`TLVIP_SRC_TMR1_HI];
    vec_pend[6] = sync2_ff[`TLVIP_SRC_FPWM];
    vec_pend[7] = sync2_ff[`TLVIP_SRC_SER1];
    vec_pend[8] = sync2_ff[`TLVIP_SRC_ADC];
    vec_pend[9] = sync2_ff[`TLVIP_SRC_PORT0] | sync2_ff[`TLVIP_SRC_TPWM];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level stack: depth 0 idle, up to three nested levels.

  tlvip_lvl_e lvl_stk_ff [3];
  logic [1:0] depth_ff;
  tlvip_lvl_e cur_lvl;
  tlvip_grant_s grant;
  logic take;
  logic ret;

  assign cur_lvl = (depth_ff == `TLVIP_DEPTH_RST) ? TLVIP_LVL_NONE :
                   lvl_stk_ff[depth_ff - 2'h1];

  tlvip_arbiter #(
    .NVEC(NVEC)
  ) u_arb (
    .pend_i(vec_pend),
    .sel_hi_i(VEC_LVL_SEL_I),
    .cur_lvl_i(cur_lvl),
    .grant_o(grant)
  );

  // A return in the same cycle as an acceptance: the return is applied
  // first, the acceptance is dropped, and the request is raised again two cycles later if still eligible.
  assign ret = CPU_RETI_I && (depth_ff != `TLVIP_DEPTH_RST);
  assign take = CPU_ACK_I && IRQ_REQ_O && !ret;

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      depth_ff <= `TLVIP_DEPTH_RST;
    end else if (ret) begin
      depth_ff <= depth_ff - 2'h1;
    end else if (take) begin
      depth_ff <= depth_ff + 2'h1;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < 3; i++) begin
        lvl_stk_ff[i] <= TLVIP_LVL_NONE;
      end
    end else if (take) begin
      lvl_stk_ff[depth_ff] <= grant.lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered vector output; request is the combinational handshake.

  logic [19:0] vec_addr_ff;
  logic [3:0] vec_idx_ff;

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      vec_addr_ff <= '0;
      vec_idx_ff <= '0;
    end else if (grant.valid) begin
      vec_addr_ff <= grant.addr;
      vec_idx_ff <= grant.vec_idx;
    end
  end

  logic gvalid_ff;
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      gvalid_ff <= 1'b0;
    end else begin
      gvalid_ff <= grant.valid && !take && !ret;
    end
  end

  // Request stands only while the registered vector matches a live grant.
  assign IRQ_REQ_O = gvalid_ff && grant.valid &&
                     (grant.vec_idx == vec_idx_ff);
  assign VEC_ADDR_O = vec_addr_ff;
  assign VEC_IDX_O = vec_idx_ff;
  assign CUR_LVL_O = cur_lvl;
  assign SRC_PEND_O = sync2_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks. Vector levels are decoded here a second time, straight from
  // the select pins, so a fault in the arbiter's own decode shows up.

  tlvip_lvl_e chk_lvl [NVEC];

  genvar gc;
  generate
    for (gc = 0; gc < NVEC; gc++) begin : g_chk_lvl
      if (gc < 2) begin : g_x
        assign chk_lvl[gc] = VEC_LVL_SEL_I[gc] ? TLVIP_LVL_HIGHEST
                                               : TLVIP_LVL_LOW;
      end else begin : g_h
        assign chk_lvl[gc] = VEC_LVL_SEL_I[gc] ? TLVIP_LVL_HIGH
                                               : TLVIP_LVL_LOW;
      end
    end
  endgenerate

  a_refuse_low_lvl: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    IRQ_REQ_O |-> chk_lvl[VEC_IDX_O] > cur_lvl)
    else $error("request at or below current level");

  a_nest_raises: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    take |=> cur_lvl > $past(cur_lvl))
    else $error("accept did not raise level");

  a_ret_restores: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (ret && depth_ff > 2'h1) |=>
      cur_lvl == $past(lvl_stk_ff[depth_ff - 2'h2], 1))
    else $error("return did not restore level");

  a_ret_idle: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (ret && depth_ff == 2'h1) |=> cur_lvl == TLVIP_LVL_NONE)
    else $error("last return did not go idle");

  a_ext0_addr: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (grant.valid && grant.vec_idx == 4'h0) |=>
      vec_addr_ff == `TLVIP_VEC1_ADDR)
    else $error("vector one address wrong");

  a_vec4_addr: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (grant.valid && grant.vec_idx == 4'h3) |=>
      vec_addr_ff == `TLVIP_VEC4_ADDR)
    else $error("vector four address wrong");

  a_shared_vec3: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    sync2_ff[`TLVIP_SRC_EXT4] |-> vec_pend[2])
    else $error("shared source not on vector three");

  a_high_first: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (grant.valid && vec_pend[0] && VEC_LVL_SEL_I[0] &&
     cur_lvl < TLVIP_LVL_HIGHEST) |-> grant.vec_idx == 4'h0)
    else $error("highest level not granted first");

  a_tie_small: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (vec_pend[4] && vec_pend[5] && VEC_LVL_SEL_I[5:4] == 2'h3 &&
     vec_pend[3:0] == 4'h0 && cur_lvl < TLVIP_LVL_HIGH)
      |-> grant.vec_idx == 4'h4)
    else $error("tie not won by smaller vector");

  a_lvl_range: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (grant.valid && grant.vec_idx > 4'h1) |->
      grant.lvl != TLVIP_LVL_HIGHEST)
    else $error("shared vector at highest level");

  a_grant_lvl: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    grant.valid |-> grant.lvl == chk_lvl[grant.vec_idx])
    else $error("granted level differs from select");

  a_low_select: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (grant.valid && !VEC_LVL_SEL_I[grant.vec_idx]) |->
      grant.lvl == TLVIP_LVL_LOW)
    else $error("unselected vector not at low level");

  a_shared_vec4: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (sync2_ff[`TLVIP_SRC_EXT3] || sync2_ff[`TLVIP_SRC_BTICK]) |->
      vec_pend[3])
    else $error("shared source not on vector four");

  a_shared_vec10: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (sync2_ff[`TLVIP_SRC_PORT0] || sync2_ff[`TLVIP_SRC_TPWM]) |->
      vec_pend[9])
    else $error("shared source not on vector ten");

  a_vec2_addr: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (IRQ_REQ_O && VEC_IDX_O == 4'h1) |->
      VEC_ADDR_O == `TLVIP_VEC2_ADDR)
    else $error("vector two address wrong");

  a_vec3_addr: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (IRQ_REQ_O && VEC_IDX_O == 4'h2) |->
      VEC_ADDR_O == `TLVIP_VEC3_ADDR)
    else $error("vector three address wrong");

  a_vec5_addr: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (IRQ_REQ_O && VEC_IDX_O == 4'h4) |->
      VEC_ADDR_O == `TLVIP_VEC5_ADDR)
    else $error("vector five address wrong");

  a_vec6_addr: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (IRQ_REQ_O && VEC_IDX_O == 4'h5) |->
      VEC_ADDR_O == `TLVIP_VEC6_ADDR)
    else $error("vector six address wrong");

  a_vec7_addr: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (IRQ_REQ_O && VEC_IDX_O == 4'h6) |->
      VEC_ADDR_O == `TLVIP_VEC7_ADDR)
    else $error("vector seven address wrong");

  a_vec8_addr: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (IRQ_REQ_O && VEC_IDX_O == 4'h7) |->
      VEC_ADDR_O == `TLVIP_VEC8_ADDR)
    else $error("vector eight address wrong");

  a_vec9_addr: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (IRQ_REQ_O && VEC_IDX_O == 4'h8) |->
      VEC_ADDR_O == `TLVIP_VEC9_ADDR)
    else $error("vector nine address wrong");

  a_vec10_addr: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (IRQ_REQ_O && VEC_IDX_O == 4'h9) |->
      VEC_ADDR_O == `TLVIP_VEC10_ADDR)
    else $error("vector ten address wrong");

  a_ack_drops: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    take |=> !IRQ_REQ_O)
    else $error("request stood on after accept");

  a_stack_push: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    take |=> CUR_LVL_O == $past(chk_lvl[VEC_IDX_O]))
    else $error("accepted level not made current");

  a_ret_wins: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (ret && CPU_ACK_I) |=> depth_ff == $past(depth_ff) - 2'h1)
    else $error("accept taken alongside a return");

  a_idle_reti: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (CPU_RETI_I && !take && depth_ff == `TLVIP_DEPTH_RST) |=>
      depth_ff == `TLVIP_DEPTH_RST)
    else $error("return at idle changed depth");

  a_full_quiet: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    depth_ff == 2'h3 |-> !IRQ_REQ_O)
    else $error("request raised at full nesting depth");

  c_accept: cover property (@(posedge MCLK_I) disable iff (!RST_N_I)
    take);
  c_nest3: cover property (@(posedge MCLK_I) disable iff (!RST_N_I)
    depth_ff == 2'h3);
  c_return: cover property (@(posedge MCLK_I) disable iff (!RST_N_I)
    ret ##1 IRQ_REQ_O);
  c_preempt: cover property (@(posedge MCLK_I) disable iff (!RST_N_I)
    take && depth_ff != `TLVIP_DEPTH_RST);
  c_ret_ack: cover property (@(posedge MCLK_I) disable iff (!RST_N_I)
    ret && CPU_ACK_I && IRQ_REQ_O);

endmodule // tlvip_ctrl

// ==== sim/tlvip_cpu_model.sv ====
`timescale 1ns/10ps
// Behavioural core: takes a presented vector some cycles after being armed.
module tlvip_cpu_model (
  input wire logic clk_i,
  input wire logic irq_i,
  input wire logic take_i,
  input wire logic [1:0] slow_i,
  input wire logic ret_i,
  output logic ack_o = 1'b0,
  output logic reti_o = 1'b0
);
  logic armed_ff = 1'b0;
  logic [1:0] cnt_ff = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // A single accept per arming, so a re-raised request is never taken twice.
  always_ff @(posedge clk_i) begin
    ack_o <= 1'b0;
    reti_o <= ret_i;
    if (take_i) begin
      armed_ff <= 1'b1;
      cnt_ff <= 2'h0;
    end else if (armed_ff && irq_i && !ack_o) begin
      if (cnt_ff == slow_i) begin
        ack_o <= 1'b1;
        armed_ff <= 1'b0;
      end else begin
        cnt_ff <= cnt_ff + 2'h1;
      end
    end
  end
endmodule // tlvip_cpu_model

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  import tlvip_pkg::*;
  localparam int VMAP [15] = '{0, 1, 2, 2, 2, 3, 3, 4, 5, 5, 6, 7, 8, 9, 9};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [14:0] src = '0;
  logic [9:0] sel = '0;
  logic take = 1'b0;
  logic ret = 1'b0;
  logic [1:0] slow = 2'h0;
  logic ack, reti, irq;
  logic [19:0] addr;
  logic [3:0] idx;
  logic [1:0] lvl;
  logic [14:0] pend;
  int failures = 0;
  int checked = 0;
  int seed = 32'heb88;
  int cycles = 0;

  tlvip_ctrl DUT (.MCLK_I(clk), .RST_N_I(rst_n), .SRC_REQ_I(src),
    .VEC_LVL_SEL_I(sel), .CPU_ACK_I(ack), .CPU_RETI_I(reti),
    .IRQ_REQ_O(irq), .VEC_ADDR_O(addr), .VEC_IDX_O(idx),
    .CUR_LVL_O(lvl), .SRC_PEND_O(pend));
  tlvip_cpu_model cpu (.clk_i(clk), .irq_i(irq), .take_i(take),
    .slow_i(slow), .ret_i(ret), .ack_o(ack), .reti_o(reti));

  initial begin
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [19:0] s, input int e);
    checked++;
    if (s !== 20'(e)) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  function automatic int lvl_of(input int v, input logic [9:0] sl);
    if (v < 2) return sl[v] ? 3 : 1;
    return sl[v] ? 2 : 1;
  endfunction

  // Best eligible vector above the current level, or 15 when none.
  function automatic int pick(input logic [14:0] s, input logic [9:0] sl,
                              input int cur);
    int best = 15;
    int bl = 0;
    int l;
    for (int i = 0; i < 15; i++) begin
      l = lvl_of(VMAP[i], sl);
      if (s[i] && l > cur && (l > bl || (l == bl && VMAP[i] < best))) begin
        bl = l;
        best = VMAP[i];
      end
    end
    return best;
  endfunction

  task automatic finish_test();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Takes nested requests until none is eligible, then unwinds them.
  task automatic run(input logic [14:0] s, input logic [9:0] sl);
    int stk [$];
    int v;
    int t;
    @(posedge clk);
    src <= s;
    sel <= sl;
    slow <= 2'($random(seed));
    stk.push_back(0);
    repeat (4) begin
      repeat (5) @(posedge clk);
      @(negedge clk);
      v = pick(s, sl, stk[$]);
      chk("pend", pend, s);
      chk("irq", irq, v != 15);
      if (v == 15) break;
      chk("addr", addr, 3 + 8 * v);
      chk("idx", idx, v);
      @(posedge clk);
      take <= 1'b1;
      @(posedge clk);
      take <= 1'b0;
      for (t = 0; t < 20 && !ack; t++) @(negedge clk);
      chk("ack", ack, 1);
      @(negedge clk);
      stk.push_back(lvl_of(v, sl));
      chk("lvl", lvl, stk[$]);
    end
    while (stk.size() > 1) begin
      @(posedge clk);
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
      repeat (3) @(negedge clk);
      void'(stk.pop_back());
      chk("restore", lvl, stk[$]);
    end
    @(posedge clk);
    src <= '0;
    repeat (6) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("rst irq", irq, 0);
    chk("rst lvl", lvl, 0);
    // A return with nothing in service must leave the depth alone.
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    repeat (3) @(negedge clk);
    chk("idle ret", lvl, 0);
    // Every source alone, at both level settings.
    for (int i = 0; i < 30; i++) begin
      run(15'(1 << (i % 15)), {10{i >= 15}});
    end
    run('1, '1);
    run('1, '0);
    for (int i = 0; i < 40; i++) run(15'($random(seed)), 10'($random(seed)));
    finish_test();
  end
endmodule // tb_top
